// [opm_card_model.sv]
// Code card presenter standing in for the camera decoder
`timescale 1ns/1ps
`default_nettype none
module opm_card_model #(
   parameter int W = 16
) (
   // Clock
   input  wire logic             clock,
   // Decoder results
   output opm_pkg::opm_code_type code_type,
   output logic                  code_valid,
   output logic [W-1:0]          code_data
);
   import opm_pkg::*;
   initial begin
      code_valid = 1'b0;
      code_type = OPM_CODE_NONE;
      code_data = 16'h5A5A;
   end
   // Data wanders between results so stale values never pass as a card
   always @(negedge clock) begin
      if (!code_valid) code_data = ~code_data;
   end
   task automatic show(input opm_code_type t, input logic [W-1:0] d);
      @(posedge clock);
      #1 code_valid = 1'b1;
      code_type = t;
      code_data = d;
      @(posedge clock);
      #1 code_valid = 1'b0;
      code_type = OPM_CODE_NONE;
   endtask
endmodule // opm_card_model
`default_nettype wire

// [opm_mode_ctrl.sv]
// Code-card parameterization mode control
// Contract
// - Entry allowed only within 10 minutes of power-on or of the last session; afterwards head locks.
// - Lock timer is held off while a session is in progress.
// - Lock engages only after more than 10 minutes without parameterization activity.
// - Button press while locked flashes all lamps, lit 2 s each cycle.
// - Mode button held over 2 s requests mode; yellow lamp flashes pending.
// - Pending: enable card enters mode, green 1 s; otherwise red 2 s.
// - In mode, valid card updates working set, green 1 s; invalid red 2 s.
// - Store card saves, leaves mode, green 1 s.
// - Short press in mode exits, restoring last saved set.
// - Cancel card exits mode, discarding unsaved changes.
// - Use card exits running modified set unsaved; power cycle reloads saved.
// - Default card loads factory defaults and exits; store requires re-entry.
`timescale 1ns/1ps
`default_nettype none
`include "opm_regs.svh"
module opm_mode_ctrl #(
   parameter int          W        = 16,
   parameter logic [W-1:0] DEF_SET = 16'h0000,
   parameter longint      LOCK_CYC = `OPM_LOCK_CYC,
   parameter int          LONG_CYC = `OPM_LONG_CYC,
   parameter int          OK_CYC   = `OPM_OK_CYC,
   parameter int          ERR_CYC  = `OPM_ERR_CYC,
   parameter int          DEB_CYC  = `OPM_DEB_CYC,
   parameter int          BLK_CYC  = `OPM_BLINK_CYC
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 nrst,
   // Operator button
   input  wire logic                 mode_button,
   // Camera decoder
   input  wire logic                 code_valid,
   input  wire opm_pkg::opm_code_type code_type,
   input  wire logic [W-1:0]         code_data,
   // Nonvolatile copy
   input  wire logic [W-1:0]         nv_data,
   output logic                      nv_write,
   output logic [W-1:0]              nv_wdata,
   // Lamps and state
   output opm_pkg::opm_lamp_type     status_feedback_lamp,
   output logic                      mode_pending_lamp,
   output logic                      all_lamps_flash,
   output logic                      head_locked,
   output logic                      param_active,
   output logic [W-1:0]              active_params
);
   import opm_pkg::*;

   opm_state_type state_r;
   logic [W-1:0]  work_q, saved_q;
   logic          boot_r, wr_work, save, restore, load_def;
   logic          btn_r, btn_cnt_done, press_long, press_short;
   logic [31:0]   deb_r, hold_r, lamp_r, blk_r, flash_r;
   logic [47:0]   lock_r;
   logic          code_ev;
   opm_lamp_type  lamp_col_r;

   // ==================================================
   // Parameter storage
   opm_param_store #(.W(W)) u_store (
      .clock     (clock),
      .nrst      (nrst),
      .wr_work   (wr_work),
      .wr_data   (code_data),
      .save      (save),
      .restore   (restore),
      .load_def  (load_def),
      .def_data  (DEF_SET),
      .boot_data (nv_data),
      .boot      (boot_r),
      .work_q    (work_q),
      .saved_q   (saved_q)
   );

   // Reload saved set after each power-up
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         boot_r <= 1'b1;
      else
         boot_r <= 1'b0;
   end

   // ==================================================
   // Button debounce and press classification
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         btn_r <= 1'b0;
         deb_r <= '0;
      end else if (mode_button == btn_r) begin
         deb_r <= '0;
      end else if (deb_r >= 32'(DEB_CYC - 1)) begin
         btn_r <= mode_button;
         deb_r <= '0;
      end else begin
         deb_r <= deb_r + 32'h1;
      end
   end

   // Long press fires once at 2 s while held; short on early release
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         hold_r <= '0;
      else if (!btn_r)
         hold_r <= '0;
      else if (!btn_cnt_done)
         hold_r <= hold_r + 32'h1;
   end
   assign btn_cnt_done = (hold_r >= 32'(LONG_CYC));
   assign press_long   = btn_r && (hold_r == 32'(LONG_CYC - 1));
   assign press_short  = btn_r && (mode_button == 1'b0) && (deb_r >= 32'(DEB_CYC - 1))
                         && !btn_cnt_done;
   assign code_ev = code_valid;

   // ==================================================
   // Time lock
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         lock_r <= '0;
      else if (state_r != OPM_IDLE && state_r != OPM_LOCKED)
         lock_r <= '0;
      else if (lock_r < 48'(LOCK_CYC))
         lock_r <= lock_r + 48'h1;
   end

   // ==================================================
   // Mode sequencing
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         state_r <= OPM_IDLE;
      else begin
         case (state_r)
            OPM_IDLE: begin
               if (lock_r >= 48'(LOCK_CYC))
                  state_r <= OPM_LOCKED;
               else if (press_long)
                  state_r <= OPM_PEND;
            end
            OPM_PEND: begin
               if (code_ev)
                  state_r <= (code_type == OPM_CODE_ENABLE) ? OPM_PARAM : OPM_IDLE;
               else if (press_short)
                  state_r <= OPM_IDLE;
            end
            OPM_PARAM: begin
               if (press_short)
                  state_r <= OPM_IDLE;
               else if (code_ev && code_type inside {OPM_CODE_STORE, OPM_CODE_CANCEL,
                                                     OPM_CODE_USE, OPM_CODE_DEFAULT})
                  state_r <= OPM_IDLE;
            end
            OPM_LOCKED: state_r <= OPM_LOCKED;
            default:    state_r <= OPM_IDLE;
         endcase
      end
   end

   // Parameter set commands
   assign wr_work  = (state_r == OPM_PARAM) && code_ev && (code_type == OPM_CODE_PARAM);
   assign save     = (state_r == OPM_PARAM) && code_ev && (code_type == OPM_CODE_STORE) && !press_short;
   assign restore  = (state_r == OPM_PARAM) && (press_short ||
                     (code_ev && code_type == OPM_CODE_CANCEL));
   assign load_def = (state_r == OPM_PARAM) && !press_short && code_ev
                     && (code_type == OPM_CODE_DEFAULT);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         nv_write <= 1'b0;
         nv_wdata <= '0;
      end else begin
         nv_write <= save;
         if (save)
            nv_wdata <= work_q;
      end
   end

   // ==================================================
   // Status lamp timing
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lamp_r     <= '0;
         lamp_col_r <= OPM_LAMP_OFF;
      end else if (state_r == OPM_PEND && code_ev) begin
         lamp_col_r <= (code_type == OPM_CODE_ENABLE) ? OPM_LAMP_GREEN : OPM_LAMP_RED;
         lamp_r     <= (code_type == OPM_CODE_ENABLE) ? 32'(OK_CYC) : 32'(ERR_CYC);
      end else if (state_r == OPM_PARAM && code_ev && !press_short
                   && code_type inside {OPM_CODE_PARAM, OPM_CODE_STORE, OPM_CODE_INVALID}) begin
         lamp_col_r <= (code_type == OPM_CODE_INVALID) ? OPM_LAMP_RED : OPM_LAMP_GREEN;
         lamp_r     <= (code_type == OPM_CODE_INVALID) ? 32'(ERR_CYC) : 32'(OK_CYC);
      end else if (lamp_r > 32'h1) begin
         lamp_r <= lamp_r - 32'h1;
      end else begin
         lamp_r     <= '0;
         lamp_col_r <= OPM_LAMP_OFF;
      end
   end

   // Slow blink for the mode pending lamp
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         blk_r <= '0;
      else
         blk_r <= (blk_r >= 32'(BLK_CYC - 1)) ? '0 : blk_r + 32'h1;
   end

   // Locked flash: on 2 s, off 2 s, restarted at cycle end while the button is held
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         flash_r <= '0;
      else if (state_r == OPM_LOCKED && btn_r && flash_r == '0)
         flash_r <= 32'(2 * ERR_CYC);
      else if (flash_r != '0)
         flash_r <= flash_r - 32'h1;
   end

   // ==================================================
   // Registered outputs
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         status_feedback_lamp <= OPM_LAMP_OFF;
         mode_pending_lamp    <= 1'b0;
         all_lamps_flash      <= 1'b0;
         head_locked          <= 1'b0;
         param_active         <= 1'b0;
         active_params        <= '0;
      end else begin
         status_feedback_lamp <= lamp_col_r;
         mode_pending_lamp    <= (state_r == OPM_PEND) && (blk_r < 32'(BLK_CYC / 2));
         all_lamps_flash      <= (flash_r > 32'(ERR_CYC));
         head_locked          <= (state_r == OPM_LOCKED);
         param_active         <= (state_r == OPM_PARAM);
         active_params        <= work_q;
      end
   end
endmodule // opm_mode_ctrl
`default_nettype wire

// [opm_mode_ctrl_checker.sv]
// Port assertions for the parameterization mode control
`timescale 1ns/1ps
`default_nettype none
module opm_mode_ctrl_checker #(
   parameter int OK_CYC  = 20,
   parameter int ERR_CYC = 40
) (
   // Clock and reset
   input wire logic                  clock,
   input wire logic                  nrst,
   // Watched ports
   input wire logic                  code_valid,
   input wire opm_pkg::opm_code_type code_type,
   input wire logic                  nv_write,
   input wire opm_pkg::opm_lamp_type status_feedback_lamp,
   input wire logic                  head_locked,
   input wire logic                  param_active
);
   import opm_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   int g_r;
   int r_r;
   wire logic pc = code_valid && param_active;
   // ====
   // Lamp run lengths, restarted on any colour change
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         g_r <= 0;
         r_r <= 0;
      end else begin
         g_r <= (status_feedback_lamp == OPM_LAMP_GREEN) ? g_r + 1 : 0;
         r_r <= (status_feedback_lamp == OPM_LAMP_RED) ? r_r + 1 : 0;
      end
   end
   property p_store_nv; pc && code_type == OPM_CODE_STORE |=> nv_write; endproperty
   a_store_nv: assert property (p_store_nv) else $error("no nv write on store");
   property p_nv_pulse; nv_write |=> !nv_write; endproperty
   a_nv_pulse: assert property (p_nv_pulse) else $error("nv write too long");
   property p_store_exit; pc && code_type == OPM_CODE_STORE |-> ##2 !param_active; endproperty
   a_store_exit: assert property (p_store_exit) else $error("store did not exit");
   property p_green_len; !head_locked && $fell(status_feedback_lamp == OPM_LAMP_GREEN) |-> g_r == OK_CYC; endproperty
   a_green_len: assert property (p_green_len) else $error("green length wrong");
   property p_red_len; !head_locked && $fell(status_feedback_lamp == OPM_LAMP_RED) |-> r_r == ERR_CYC; endproperty
   a_red_len: assert property (p_red_len) else $error("red length wrong");
   property p_lock_hold; head_locked |=> head_locked; endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock released");
   property p_exit; pc && code_type inside {OPM_CODE_CANCEL, OPM_CODE_USE, OPM_CODE_DEFAULT} |-> ##2 !param_active;
   endproperty
   a_exit: assert property (p_exit) else $error("exit card ignored");
   property p_enable_ign; pc && code_type == OPM_CODE_ENABLE |-> ##2 param_active; endproperty
   a_enable_ign: assert property (p_enable_ign) else $error("enable left mode");
endmodule // opm_mode_ctrl_checker
`default_nettype wire

// [opm_mode_ctrl_tb.sv]
// Self-checking bench for the parameterization mode control
`timescale 1ns/1ps
`default_nettype none
module opm_mode_ctrl_tb;
   import opm_pkg::*;
   localparam int W = 16, OK = 20, ERR = 40, LNG = 50, LCK = 2000;
   localparam logic [W-1:0] DEF = 16'hA5C3;
   logic clock = 1'b0, nrst = 1'b0, mode_button = 1'b0, code_valid, nv_write, mode_pending_lamp;
   logic all_lamps_flash, head_locked, param_active;
   logic [W-1:0] code_data, nv_data, nv_wdata, active_params, saved, d;
   opm_code_type code_type;
   opm_lamp_type status_feedback_lamp, last_l = OPM_LAMP_OFF, lamp_q[$];
   logic [W-1:0] nv_q[$];
   int error_cnt = 0, num_checks = 0, n;
   logic [31:0] rng = 32'h88CC1F04;
   always #2.5 clock = ~clock;
   opm_card_model #(.W(W)) i_card (.clock(clock), .code_valid(code_valid), .code_type(code_type),
      .code_data(code_data));
   opm_mode_ctrl #(.W(W), .DEF_SET(DEF), .LOCK_CYC(LCK), .LONG_CYC(LNG), .OK_CYC(OK), .ERR_CYC(ERR),
      .DEB_CYC(3), .BLK_CYC(8)) i_dut (.clock(clock), .nrst(nrst), .mode_button(mode_button),
      .code_valid(code_valid), .code_type(code_type), .code_data(code_data), .nv_data(nv_data),
      .nv_write(nv_write), .nv_wdata(nv_wdata), .status_feedback_lamp(status_feedback_lamp),
      .mode_pending_lamp(mode_pending_lamp), .all_lamps_flash(all_lamps_flash),
      .head_locked(head_locked), .param_active(param_active), .active_params(active_params));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk_val(input string nm, input logic [W-1:0] e, input logic [W-1:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_lamp(input opm_lamp_type e, input opm_lamp_type g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] status_feedback_lamp exp %0d got %0d", e, g);
      end
   endtask
   task automatic end_sim();
      if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ====
   // Result watcher and nonvolatile memory stand-in
   always @(posedge clock) begin
      if (nrst && status_feedback_lamp != OPM_LAMP_OFF && last_l == OPM_LAMP_OFF) begin
         if (lamp_q.size() == 0) chk_lamp(OPM_LAMP_OFF, status_feedback_lamp);
         else chk_lamp(lamp_q.pop_front(), status_feedback_lamp);
      end
      last_l <= status_feedback_lamp;
      if (nrst && nv_write === 1'b1) begin
         nv_data <= nv_wdata;
         if (nv_q.size() == 0) chk_val("nv_write", 16'h0000, 16'h0001);
         else chk_val("nv_wdata", nv_q.pop_front(), nv_wdata);
      end
   end
   task automatic pwr(input int c);
      #1 nrst = 1'b0;
      repeat (c) @(posedge clock);
      #1 nrst = 1'b1;
      repeat (4) @(posedge clock);
   endtask
   task automatic hold(input int c);
      @(posedge clock);
      #1 mode_button = 1'b1;
      repeat (c) @(posedge clock);
      #1 mode_button = 1'b0;
      repeat (10) @(posedge clock);
   endtask
   task automatic card(input opm_code_type t, input logic [W-1:0] v);
      i_card.show(t, v);
      repeat (3) @(posedge clock);
      for (n = 0; status_feedback_lamp !== OPM_LAMP_OFF && n < 100; n++) @(negedge clock);
      @(posedge clock);
   endtask
   task automatic enter();
      hold(LNG + 10);
      lamp_q.push_back(OPM_LAMP_GREEN);
      card(OPM_CODE_ENABLE, 16'h0000);
   endtask
   initial begin
      #(5 * 20000);
      error_cnt++;
      end_sim();
   end
   initial begin
      rng = xs(rng);
      nv_data = rng[W-1:0];
      saved = nv_data;
      pwr(12);
      card(OPM_CODE_PARAM, 16'h0F0F);
      chk_val("active_params", saved, active_params);
      hold(LNG + 10);
      for (n = 0; mode_pending_lamp !== 1'b1 && n < 20; n++) @(negedge clock);
      chk_val("mode_pending_lamp", 16'h0001, 16'(mode_pending_lamp));
      lamp_q.push_back(OPM_LAMP_RED);
      card(OPM_CODE_INVALID, 16'h0000);
      chk_val("param_active", 16'h0000, 16'(param_active));
      chk_val("mode_pending_lamp", 16'h0000, 16'(mode_pending_lamp));
      for (int k = 0; k < 6; k++) begin
         enter();
         chk_val("param_active", 16'h0001, 16'(param_active));
         rng = xs(rng);
         d = (k == 5) ? DEF : rng[W-1:0];
         if (k != 5) lamp_q.push_back(OPM_LAMP_GREEN);
         if (k != 5) card(OPM_CODE_PARAM, d);
         chk_val("active_params", d, active_params);
         if (k == 0) lamp_q.push_back(OPM_LAMP_RED);
         if (k == 0) card(OPM_CODE_INVALID, 16'h0000);
         if (k == 0) card(OPM_CODE_ENABLE, 16'h0000);
         if (k == 0 || k == 5) nv_q.push_back(d);
         if (k == 0 || k == 5) lamp_q.push_back(OPM_LAMP_GREEN);
         if (k == 0 || k == 5) card(OPM_CODE_STORE, 16'h0000);
         if (k == 0 || k == 5) saved = d;
         if (k == 1) hold(10);
         if (k == 2) card(OPM_CODE_CANCEL, 16'h0000);
         if (k == 3) card(OPM_CODE_USE, 16'h0000);
         if (k == 4) card(OPM_CODE_DEFAULT, 16'h0000);
         chk_val("param_active", 16'h0000, 16'(param_active));
         chk_val("active_params", k == 3 ? d : (k == 4 ? DEF : saved), active_params);
         if (k == 3) pwr(3);
         if (k == 3) chk_val("active_params", saved, active_params);
      end
      chk_val("head_locked", 16'h0000, 16'(head_locked));
      repeat (LCK - 100) @(posedge clock);
      chk_val("head_locked", 16'h0000, 16'(head_locked));
      repeat (200) @(posedge clock);
      chk_val("head_locked", 16'h0001, 16'(head_locked));
      #1 mode_button = 1'b1;
      for (n = 0; all_lamps_flash !== 1'b1 && n < 200; n++) @(negedge clock);
      for (n = 0; all_lamps_flash === 1'b1 && n < 200; n++) @(negedge clock);
      @(posedge clock);
      #1 mode_button = 1'b0;
      chk_val("all_lamps_flash", 16'(ERR), 16'(n));
      hold(LNG + 10);
      card(OPM_CODE_ENABLE, 16'h0000);
      chk_val("param_active", 16'h0000, 16'(param_active));
      chk_val("queues", 16'h0000, 16'(lamp_q.size() + nv_q.size()));
      end_sim();
   end
endmodule // opm_mode_ctrl_tb
bind opm_mode_ctrl opm_mode_ctrl_checker #(.OK_CYC(OK_CYC), .ERR_CYC(ERR_CYC)) i_chk (.clock(clock), .nrst(nrst),
   .code_valid(code_valid), .code_type(code_type), .nv_write(nv_write),
   .status_feedback_lamp(status_feedback_lamp), .head_locked(head_locked), .param_active(param_active));
`default_nettype wire

// [opm_param_store.sv]
// Working and saved parameter set storage with registered read-out
`timescale 1ns/1ps
`default_nettype none
module opm_param_store #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         nrst,
   // Commands
   input  wire logic         wr_work,
   input  wire logic [W-1:0] wr_data,
   input  wire logic         save,
   input  wire logic         restore,
   input  wire logic         load_def,
   input  wire logic [W-1:0] def_data,
   input  wire logic [W-1:0] boot_data,
   input  wire logic         boot,
   // Registered outputs
   output logic      [W-1:0] work_q,
   output logic      [W-1:0] saved_q
);
   // Saved set stands for the nonvolatile copy; boot reloads it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         saved_q <= '0;
      else if (boot)
         saved_q <= boot_data;
      else if (save)
         saved_q <= work_q;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         work_q <= '0;
      else if (boot)
         work_q <= boot_data;
      else if (load_def)
         work_q <= def_data;
      else if (restore)
         work_q <= saved_q;
      else if (wr_work)
         work_q <= wr_data;
   end
endmodule // opm_param_store
`default_nettype wire

// [opm_pkg.sv]
// Types for the optical parameterization mode control block
`default_nettype none
package opm_pkg;
   typedef enum logic [2:0] {
      OPM_CODE_NONE, OPM_CODE_ENABLE, OPM_CODE_PARAM, OPM_CODE_STORE,
      OPM_CODE_CANCEL, OPM_CODE_USE, OPM_CODE_DEFAULT, OPM_CODE_INVALID
   } opm_code_type;
   typedef enum logic [1:0] {OPM_LAMP_OFF, OPM_LAMP_GREEN, OPM_LAMP_RED} opm_lamp_type;
   typedef enum {OPM_IDLE, OPM_PEND, OPM_PARAM, OPM_LOCKED} opm_state_type;
endpackage
`default_nettype wire

// [opm_regs.svh]
// Constants for the optical parameterization mode control block
`ifndef OPM_REGS_SVH
`define OPM_REGS_SVH
`define OPM_CLK_HZ        200000000
`define OPM_LOCK_MIN      10
// Lock span exceeds 32 bits, so it is reckoned in 64-bit arithmetic
`define OPM_LOCK_CYC      (64'(`OPM_LOCK_MIN) * 64'(60) * 64'(`OPM_CLK_HZ))
`define OPM_LONG_MS       2000
`define OPM_LONG_CYC      (`OPM_LONG_MS * (`OPM_CLK_HZ / 1000))
`define OPM_OK_MS         1000
`define OPM_OK_CYC        (`OPM_OK_MS * (`OPM_CLK_HZ / 1000))
`define OPM_ERR_MS        2000
`define OPM_ERR_CYC       (`OPM_ERR_MS * (`OPM_CLK_HZ / 1000))
`define OPM_DEB_US        10
`define OPM_DEB_CYC       (`OPM_DEB_US * (`OPM_CLK_HZ / 1000000))
`define OPM_BLINK_MS      250
`define OPM_BLINK_CYC     (`OPM_BLINK_MS * (`OPM_CLK_HZ / 1000))
`endif
